// File: design/timer_defs.svh
// Register offsets, field positions and reset values of the timer pair
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// ==========================================================
// Per-timer register offsets, within a 64-byte timer window
`define TMR_OFF_CTRL 6'h00
`define TMR_OFF_PSC 6'h04
`define TMR_OFF_ARR 6'h08
`define TMR_OFF_CNT 6'h0C
`define TMR_OFF_RCR 6'h10
`define TMR_OFF_DTG 6'h14
`define TMR_OFF_CCMODE 6'h18
`define TMR_OFF_CCR0 6'h1C
// ==========================================================
// Window bases and shared registers
`define TMR_ADV_BASE 8'h00
`define TMR_GP_BASE 8'h40
`define TMR_STATUS 8'h80
`define TMR_MASK 8'h84
`define TMR_DMA_EN 8'h88
// ==========================================================
// Control register fields
`define TMR_CTRL_EN 0
`define TMR_CTRL_DOWN 1
`define TMR_CTRL_ONEPULSE 2
`define TMR_CTRL_FREEZE 3
`define TMR_CTRL_SLV_LO 4
`define TMR_CTRL_SLV_HI 5
`define TMR_CTRL_BRK_EN 6
`define TMR_CTRL_OUT_EN 7
// ==========================================================
// Status layout: timer t uses bits t*8 upward
`define TMR_ST_UPDATE 0
`define TMR_ST_CC0 1
`define TMR_ST_BRAKE 5
`define TMR_ST_STRIDE 8
// ==========================================================
// Reset values
`define TMR_CTRL_RST 8'h00
`define TMR_PSC_RST 16'h0000
`define TMR_ARR_RST 32'h0000FFFF
`define TMR_RCR_RST 8'h00
`define TMR_DTG_RST 8'h00
`define TMR_CCMODE_RST 8'h00
`define TMR_CCR_RST 32'h00000000
`endif

// File: design/timer_pkg.sv
// Types shared by the timer pair and its channel slices
`default_nettype none
package timer_pkg;
    // Slave mode of a counter: what clocks, resets or captures it
    typedef enum logic [1:0] {SLV_NONE, SLV_ENCODER, SLV_LINK, SLV_HALL} slave_mode_t;
    // Channel function
    typedef enum logic [1:0] {CH_OFF, CH_CAPTURE, CH_TOGGLE, CH_PWM} ch_mode_t;
endpackage
`default_nettype wire

// File: design/chan_if.sv
// Signals between a timer counter and one of its channel slices
`default_nettype none
interface chan_if;
    logic [31:0] cnt; // Counter value
    logic [31:0] cmp; // Compare value
    timer_pkg::ch_mode_t mode; // Channel function
    logic cap_in; // Filtered capture input level
    logic [31:0] cap; // Captured counter value
    logic ref_lvl; // Reference output level
    logic event_p; // Match or capture pulse
    modport timer (output cnt, cmp, mode, cap_in, input cap, ref_lvl, event_p);
    modport chan (input cnt, cmp, mode, cap_in, output cap, ref_lvl, event_p);
endinterface
`default_nettype wire

// File: design/timer_channel.sv
// One capture/compare channel slice
`default_nettype none
module timer_channel
(
    input wire logic sys_clk,
    input wire logic rstn,
    chan_if.chan ch
);
    logic match_q; // Counter equalled compare last cycle
    logic in_q; // Capture input last cycle
    logic ref_q;
    logic event_q;
    logic [31:0] cap_q;
    logic match;

    assign match = (ch.cnt == ch.cmp);
    assign ch.ref_lvl = ref_q;
    assign ch.event_p = event_q;
    assign ch.cap = cap_q;

    // ==========================================================
    // Edge history
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            match_q <= 1'b0;
            in_q <= 1'b0;
        end
        else
        begin
            match_q <= match;
            in_q <= ch.cap_in;
        end
    end

    // ==========================================================
    // Reference level per function
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ref_q <= 1'b0;
        else
        begin
            unique case (ch.mode)
                timer_pkg::CH_OFF: ref_q <= 1'b0;
                timer_pkg::CH_CAPTURE: ref_q <= 1'b0; // Input: nothing driven
                timer_pkg::CH_TOGGLE: ref_q <= ref_q ^ (match && !match_q);
                timer_pkg::CH_PWM: ref_q <= (ch.cnt < ch.cmp);
            endcase
        end
    end

    // ==========================================================
    // Capture on rising input, event on match entry or capture
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cap_q <= 32'h00000000;
            event_q <= 1'b0;
        end
        else if (ch.mode == timer_pkg::CH_CAPTURE)
        begin
            event_q <= ch.cap_in && !in_q;
            if (ch.cap_in && !in_q)
                cap_q <= ch.cnt;
        end
        else
            event_q <= (ch.mode != timer_pkg::CH_OFF) && match && !match_q;
    end
endmodule
`default_nettype wire

// File: design/timer_pair.sv
// Advanced-control and general-purpose timers behind an AHB-Lite slave
`include "timer_defs.svh"
`default_nettype none
module timer_pair #(
    parameter int GP_CNT_W = 16 // General counter width, 16 or 32
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [7:0] ch_in,
    input wire logic brake_in,
    input wire logic dbg_halt,
    output logic [7:0] ch_out,
    output logic [2:0] chn_out,
    output logic [1:0] dma_req,
    output logic irq
);
    localparam logic [31:0] ADV_MASK = 32'h0000FFFF;
    localparam logic [31:0] GP_MASK = 32'((64'h1 << GP_CNT_W) - 64'h1);

    // ==========================================================
    // Bus slave state
    logic wr_pend_q; // Write data phase in progress
    logic rd_pend_q; // Read data phase, wait state
    logic [7:0] addr_q; // Latched address
    logic hready_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_d;
    logic accept;

    // ==========================================================
    // Registers, index 0 advanced, 1 general
    logic [7:0] ctrl_q [2];
    logic [15:0] psc_q [2];
    logic [31:0] arr_q [2];
    logic [7:0] rcr_q [2];
    logic [7:0] dtg_q;
    logic [7:0] ccmode_q [2];
    logic [31:0] ccr_q [8];
    logic [15:0] status_q; // Sticky events
    logic [15:0] mask_q; // Interrupt enables
    logic [1:0] dma_en_q; // DMA request enables

    // ==========================================================
    // Counter state
    logic [31:0] cnt_q [2];
    logic [15:0] psc_cnt_q [2];
    logic [7:0] rep_q [2];
    logic [1:0] upd_q; // Registered update pulse
    logic [1:0] run, step, up, ovf, upd_ev, trig, enc_step, enc_up;
    logic [1:0] hall_prev_q, hall, hall_chg, a_prev_q, halt_frz;
    timer_pkg::slave_mode_t slv [2];

    // ==========================================================
    // Input synchroniser: brake in bit 8
    logic [8:0] s1_q, s2_q, s3_q, filt_q;

    // ==========================================================
    // Dead time and outputs
    logic [7:0] dt_q [3];
    logic [2:0] ref_prev_q;
    logic [7:0] ch_out_q;
    logic [2:0] chn_out_q;
    logic [1:0] dma_q;
    logic irq_q;
    logic brk;
    logic [31:0] cap_val [8]; // Captured values of the eight channels
    logic [7:0] g_ev; // Channel event pulses
    logic [7:0] ref_lv; // Channel reference levels

    chan_if chb[8] ();

    assign accept = hsel && hready && htrans[1];
    assign hreadyout = hready_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0; // Always OKAY
    assign ch_out = ch_out_q;
    assign chn_out = chn_out_q;
    assign dma_req = dma_q;
    assign irq = irq_q;
    assign brk = ctrl_q[0][`TMR_CTRL_BRK_EN] && filt_q[8];

    // ==========================================================
    // AHB-Lite: writes zero wait, reads one wait state
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hready_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= accept && hwrite;
            rd_pend_q <= accept && !hwrite;
            if (accept)
                addr_q <= {haddr[7:2], 2'b00}; // Whole words only
            // Read data out of a register, so stall one cycle
            if (accept && !hwrite)
                hready_q <= 1'b0;
            else if (rd_pend_q)
            begin
                hready_q <= 1'b1;
                hrdata_q <= rd_d;
            end
        end
    end

    // ==========================================================
    // Read mux; unmapped reads give zero
    always_comb
    begin
        int t;
        rd_d = 32'h00000000;
        t = int'(addr_q[6]);
        if (addr_q == `TMR_STATUS)
            rd_d = {16'h0000, status_q};
        else if (addr_q == `TMR_MASK)
            rd_d = {16'h0000, mask_q};
        else if (addr_q == `TMR_DMA_EN)
            rd_d = {30'h00000000, dma_en_q};
        else if (!addr_q[7])
        begin
            unique case (addr_q[5:0])
                `TMR_OFF_CTRL: rd_d = {24'h000000, ctrl_q[t]};
                `TMR_OFF_PSC: rd_d = {16'h0000, psc_q[t]};
                `TMR_OFF_ARR: rd_d = arr_q[t];
                `TMR_OFF_CNT: rd_d = cnt_q[t];
                `TMR_OFF_RCR: rd_d = (t == 0) ? {24'h000000, rcr_q[0]} : 32'h00000000;
                `TMR_OFF_DTG: rd_d = (t == 0) ? {24'h000000, dtg_q} : 32'h00000000;
                `TMR_OFF_CCMODE: rd_d = {24'h000000, ccmode_q[t]};
                default: rd_d = 32'h00000000;
            endcase
            for (int c = 0; c < 4; c++)
            begin
                if (addr_q[5:0] == `TMR_OFF_CCR0 + 6'(4 * c))
                    rd_d = (ccmode_q[t][2*c +: 2] == 2'(timer_pkg::CH_CAPTURE))
                        ? cap_val[t*4 + c] : ccr_q[t*4 + c];
            end
        end
    end

    // ==========================================================
    // Plain configuration registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int t = 0; t < 2; t++)
            begin
                psc_q[t] <= `TMR_PSC_RST;
                arr_q[t] <= `TMR_ARR_RST;
                rcr_q[t] <= `TMR_RCR_RST;
                ccmode_q[t] <= `TMR_CCMODE_RST;
            end
            for (int i = 0; i < 8; i++)
                ccr_q[i] <= `TMR_CCR_RST;
            dtg_q <= `TMR_DTG_RST;
            mask_q <= 16'h0000;
            dma_en_q <= 2'b00;
        end
        else if (wr_pend_q)
        begin
            if (addr_q == `TMR_MASK)
                mask_q <= hwdata[15:0];
            else if (addr_q == `TMR_DMA_EN)
                dma_en_q <= hwdata[1:0];
            else if (!addr_q[7])
            begin
                unique case (addr_q[5:0])
                    `TMR_OFF_PSC: psc_q[addr_q[6]] <= hwdata[15:0];
                    `TMR_OFF_ARR: arr_q[addr_q[6]] <= hwdata & (addr_q[6] ? GP_MASK : ADV_MASK);
                    `TMR_OFF_RCR: rcr_q[addr_q[6]] <= hwdata[7:0];
                    `TMR_OFF_DTG: dtg_q <= addr_q[6] ? dtg_q : hwdata[7:0];
                    `TMR_OFF_CCMODE: ccmode_q[addr_q[6]] <= hwdata[7:0];
                    default: ;
                endcase
                for (int c = 0; c < 4; c++)
                begin
                    if (addr_q[5:0] == `TMR_OFF_CCR0 + 6'(4 * c))
                        ccr_q[{addr_q[6], 2'(c)}] <= hwdata;
                end
            end
        end
    end

    // ==========================================================
    // Control: one-pulse stops the counter, brake drops output enable
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q[0] <= `TMR_CTRL_RST;
            ctrl_q[1] <= `TMR_CTRL_RST;
        end
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                if (wr_pend_q && !addr_q[7] && addr_q[6] == 1'(t)
                    && addr_q[5:0] == `TMR_OFF_CTRL)
                    ctrl_q[t] <= hwdata[7:0];
                if (upd_ev[t] && ctrl_q[t][`TMR_CTRL_ONEPULSE])
                    ctrl_q[t][`TMR_CTRL_EN] <= 1'b0;
            end
            ctrl_q[1][`TMR_CTRL_BRK_EN] <= 1'b0; // General timer has no brake
            if (brk)
                ctrl_q[0][`TMR_CTRL_OUT_EN] <= 1'b0;
        end
    end

    // ==========================================================
    // Pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= 9'h000;
            s2_q <= 9'h000;
            s3_q <= 9'h000;
            filt_q <= 9'h000;
        end
        else
        begin
            s1_q <= {brake_in, ch_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        end
    end

    // ==========================================================
    // Counter control terms for both timers
    always_comb
    begin
        for (int t = 0; t < 2; t++)
        begin
            slv[t] = timer_pkg::slave_mode_t'(ctrl_q[t][`TMR_CTRL_SLV_HI:`TMR_CTRL_SLV_LO]);
            halt_frz[t] = dbg_halt && ctrl_q[t][`TMR_CTRL_FREEZE];
            run[t] = ctrl_q[t][`TMR_CTRL_EN] && !halt_frz[t];
            // Encoder x2: count on each edge of input A, direction from B
            enc_step[t] = filt_q[t*4] != a_prev_q[t];
            enc_up[t] = filt_q[t*4] ^ filt_q[t*4 + 1];
            hall[t] = ^filt_q[t*4 +: 3];
            hall_chg[t] = (slv[t] == timer_pkg::SLV_HALL) && (hall[t] != hall_prev_q[t]);
            trig[t] = (slv[t] == timer_pkg::SLV_LINK) && upd_q[1 - t];
            if (slv[t] == timer_pkg::SLV_ENCODER)
            begin
                step[t] = run[t] && enc_step[t];
                up[t] = enc_up[t];
            end
            else
            begin
                step[t] = run[t] && (psc_cnt_q[t] == psc_q[t]);
                up[t] = !ctrl_q[t][`TMR_CTRL_DOWN];
            end
            ovf[t] = step[t] && (up[t] ? (cnt_q[t] == arr_q[t]) : (cnt_q[t] == 32'h00000000));
            upd_ev[t] = ovf[t] && (rep_q[t] == 8'h00);
        end
    end

    // ==========================================================
    // Prescalers, counters and repetition counts
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int t = 0; t < 2; t++)
            begin
                psc_cnt_q[t] <= 16'h0000;
                cnt_q[t] <= 32'h00000000;
                rep_q[t] <= 8'h00;
            end
            upd_q <= 2'b00;
            a_prev_q <= 2'b00;
            hall_prev_q <= 2'b00;
        end
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                a_prev_q[t] <= filt_q[t*4];
                hall_prev_q[t] <= hall[t];
                if (run[t])
                    psc_cnt_q[t] <= (psc_cnt_q[t] == psc_q[t]) ? 16'h0000 : psc_cnt_q[t] + 16'h0001;
                if (wr_pend_q && !addr_q[7] && addr_q[6] == 1'(t)
                    && addr_q[5:0] == `TMR_OFF_CNT)
                    cnt_q[t] <= hwdata & (t == 1 ? GP_MASK : ADV_MASK);
                else if (trig[t])
                    cnt_q[t] <= 32'h00000000;
                else if (step[t])
                begin
                    if (ovf[t])
                        cnt_q[t] <= up[t] ? 32'h00000000 : arr_q[t];
                    else
                        cnt_q[t] <= (up[t] ? cnt_q[t] + 32'h1 : cnt_q[t] - 32'h1)
                            & (t == 1 ? GP_MASK : ADV_MASK);
                end
                // Only the advanced timer has a repetition count
                if (ovf[t])
                    rep_q[t] <= (rep_q[t] == 8'h00) ? ((t == 0) ? rcr_q[0] : 8'h00)
                        : rep_q[t] - 8'h01;
            end
            upd_q <= upd_ev;
        end
    end

    // ==========================================================
    // Channel slices, four per timer
    for (genvar i = 0; i < 8; i++)
    begin : g_ch
        assign chb[i].cnt = cnt_q[i / 4];
        assign chb[i].cmp = ccr_q[i];
        assign chb[i].mode = timer_pkg::ch_mode_t'(ccmode_q[i / 4][2*(i % 4) +: 2]);
        assign chb[i].cap_in = (i % 4 == 0 && slv[i / 4] == timer_pkg::SLV_HALL)
            ? hall_chg[i / 4] : filt_q[i];
        assign cap_val[i] = chb[i].cap;
        timer_channel u_ch (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .ch(chb[i])
        );
    end

    // ==========================================================
    // Sticky status, cleared by a read; a new event wins over the clear
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            status_q <= 16'h0000;
        else
        begin
            logic [15:0] set;
            set = 16'h0000;
            for (int t = 0; t < 2; t++)
            begin
                set[t*`TMR_ST_STRIDE + `TMR_ST_UPDATE] = upd_q[t];
                for (int c = 0; c < 4; c++)
                    set[t*`TMR_ST_STRIDE + `TMR_ST_CC0 + c] = g_ev[t*4 + c];
            end
            set[`TMR_ST_BRAKE] = brk && ctrl_q[0][`TMR_CTRL_OUT_EN];
            status_q <= ((rd_pend_q && addr_q == `TMR_STATUS) ? 16'h0000 : status_q) | set;
        end
    end

    for (genvar i = 0; i < 8; i++)
    begin : g_evt
        assign g_ev[i] = chb[i].event_p;
    end

    // ==========================================================
    // Interrupt and per-timer DMA requests
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_q <= 1'b0;
            dma_q <= 2'b00;
        end
        else
        begin
            irq_q <= |(status_q & mask_q);
            dma_q <= upd_q & dma_en_q;
        end
    end

    // ==========================================================
    // Dead-time counters restart on each reference edge
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int c = 0; c < 3; c++)
                dt_q[c] <= 8'h00;
            ref_prev_q <= 3'b000;
        end
        else
        begin
            for (int c = 0; c < 3; c++)
            begin
                ref_prev_q[c] <= ref_lv[c];
                if (ref_lv[c] != ref_prev_q[c])
                    dt_q[c] <= dtg_q;
                else if (dt_q[c] != 8'h00)
                    dt_q[c] <= dt_q[c] - 8'h01;
            end
        end
    end

    for (genvar i = 0; i < 8; i++)
    begin : g_ref
        assign ref_lv[i] = chb[i].ref_lvl;
    end

    // ==========================================================
    // Output pins; both legs low during dead time, brake or debug halt
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ch_out_q <= 8'h00;
            chn_out_q <= 3'b000;
        end
        else
        begin
            logic adv_ok;
            adv_ok = ctrl_q[0][`TMR_CTRL_OUT_EN] && !halt_frz[0];
            for (int c = 0; c < 3; c++)
            begin
                ch_out_q[c] <= adv_ok && ref_lv[c] && dt_q[c] == 8'h00;
                chn_out_q[c] <= adv_ok && !ref_lv[c] && dt_q[c] == 8'h00;
            end
            ch_out_q[3] <= adv_ok && ref_lv[3];
            ch_out_q[7:4] <= halt_frz[1] ? 4'h0 : ref_lv[7:4];
        end
    end
endmodule
`default_nettype wire

// File: bench/timer_pair_asserts.sv
// Port-level checker for the timer pair
`default_nettype none
module timer_pair_asserts #(
    parameter int GP_CNT_W = 16 // General counter width
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [7:0] ch_in,
    input wire logic brake_in,
    input wire logic dbg_halt,
    input wire logic [7:0] ch_out,
    input wire logic [2:0] chn_out,
    input wire logic [1:0] dma_req,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Bus steps
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence rd_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wr_taken;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    // Read answer: exactly one wait state, then data
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    // ==========================================================
    // Assertions
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (rd_taken |=> one_wait)
        else $error("read answer not after one wait");
    a_write_nowait: assert property (wr_taken |=> hreadyout)
        else $error("write stalled the bus");
    a_wait_single: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    a_idle_ready: assert property (hreadyout && !rd_taken |=> hreadyout)
        else $error("wait state without a read");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved outside a read");
    // Shoot-through guard: a pair never has both legs on
    a_legs_apart: assert property ((ch_out[2:0] & chn_out) == 3'h0)
        else $error("both legs of a pair on");
    // Switches off while held in reset
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> ch_out == 8'h00 && chn_out == 3'h0 && irq == 1'b0 && dma_req == 2'h0)
        else $error("outputs active in reset");
endmodule
bind timer_pair timer_pair_asserts #(.GP_CNT_W(GP_CNT_W)) timer_pair_asserts_inst (.sys_clk,
    .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
    .hresp, .ch_in, .brake_in, .dbg_halt, .ch_out, .chn_out, .dma_req, .irq);
`default_nettype wire

// File: bench/field_model.sv
// Field side: encoder on the general timer inputs and the brake source
`default_nettype none
module field_model
(
    input wire logic sys_clk,
    output logic [7:0] ch_in,
    output logic brake_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sensors idle low, brake released
    initial
    begin
        ch_in = 8'h00;
        brake_in = 1'b0;
    end
    // One step: B settles first so A never moves with it
    task automatic step(input logic up);
        ch_in[5] <= up ? ch_in[4] : ~ch_in[4];
        repeat (8) @(posedge sys_clk);
        ch_in[4] <= ~ch_in[4];
        repeat (8) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the timer pair
`default_nettype none
`define CHK(a, e) \
    begin \
        samples_checked++; \
        if ((a) !== (e)) \
        begin \
            miscompares++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dbg_halt = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq, brake_in;
    logic [31:0] hrdata, r, s;
    logic [7:0] ch_in, ch_out;
    logic [2:0] chn_out;
    logic [1:0] dma_req;
    int miscompares = 0, samples_checked = 0, cyc = 0, n = 0;
    timer_pair timer_pair_inst (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ch_in,
        .brake_in, .dbg_halt, .ch_out, .chn_out, .dma_req, .irq);
    field_model field_model_inst (.sys_clk, .ch_in, .brake_in);
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // One single transfer; read data lands in r
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask
    // Ready and data sampled mid-cycle, clear of the edge race; returns on that edge
    task automatic wait_ready();
        logic rdy;
        do
        begin
            @(negedge sys_clk);
            rdy = hreadyout;
            r = hrdata;
            @(posedge sys_clk);
        end
        while (rdy !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    // Cycles until the next transfer request of timer b
    task automatic wait_dma(input int b);
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (dma_req[b] !== 1'b1 && n < 300);
    endtask
    task automatic check_reset();
        rd(8'h08);
        `CHK(r, 32'h0000FFFF)
        wr(8'hC0, 32'h5A);
        rd(8'hC0);
        `CHK(r, 32'h0)
        rd(8'h50);
        `CHK(r, 32'h0)
    endtask
    // Prescale 2, period 4, update every third overflow
    task automatic check_repeat();
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h3);
        wr(8'h10, 32'h2);
        wr(8'h88, 32'h1);
        wr(8'h84, 32'h1);
        wr(8'h00, 32'h1);
        wait_dma(0);
        wait_dma(0);
        `CHK(n, 32'h18)
        `CHK(irq, 1'b1)
        wr(8'h00, 32'h0);
        rd(8'h80);
        `CHK(r[0], 1'b1)
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        wr(8'h84, 32'h0);
    endtask
    task automatic check_down();
        wr(8'h48, 32'h5);
        wr(8'h88, 32'h2);
        wr(8'h40, 32'h3);
        wait_dma(1);
        wait_dma(1);
        `CHK(n, 32'h6)
        wr(8'h40, 32'h0);
        wr(8'h48, 32'hFFFF);
    endtask
    task automatic check_encoder();
        wr(8'h40, 32'h11);
        wr(8'h4C, 32'h0);
        repeat (5) field_model_inst.step(1'b1);
        rd(8'h4C);
        `CHK(r, 32'h5)
        repeat (2) field_model_inst.step(1'b0);
        rd(8'h4C);
        `CHK(r, 32'h3)
        wr(8'h40, 32'h0);
    endtask
    // PWM with dead time, then the brake trips the pairs
    task automatic check_brake();
        wr(8'h14, 32'h2);
        wr(8'h18, 32'h3);
        wr(8'h1C, 32'h3);
        wr(8'h08, 32'h7);
        wr(8'h00, 32'hC1);
        s = 32'h0;
        repeat (40)
        begin
            @(negedge sys_clk);
            s[1:0] = s[1:0] | {chn_out[0], ch_out[0]};
        end
        `CHK(s[1:0], 2'h3)
        @(posedge sys_clk);
        field_model_inst.brake_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        `CHK({ch_out[2:0], chn_out}, 6'h00)
        rd(8'h00);
        `CHK(r[7:0], 8'h41)
        rd(8'h80);
        `CHK(r[5], 1'b1)
        field_model_inst.brake_in <= 1'b0;
    endtask
    task automatic check_freeze();
        wr(8'h00, 32'h89);
        repeat (20) @(posedge sys_clk);
        dbg_halt <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(8'h0C);
        s = r;
        repeat (10) @(posedge sys_clk);
        rd(8'h0C);
        `CHK(r, s)
        `CHK({ch_out[2:0], chn_out}, 6'h00)
        dbg_halt <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(8'h0C);
        `CHK(r !== s, 1'b1)
    endtask
    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check_reset();
        check_repeat();
        check_down();
        check_encoder();
        check_brake();
        check_freeze();
        stop_test();
    end
endmodule
`default_nettype wire
